/* hdl/rqh_fifo.sv */
// word fifo with a registered output stage
// assumes synchronous valid/ready on both sides
`timescale 1ns/1ns
`include "rqh_regs.svh"
module rqh_fifo #(
    parameter int WIDTH = `RQH_FIFO_W,
    parameter int DEPTH = `RQH_FIFO_D
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    rqh_stream_if.dst wr, // filling side
    rqh_stream_if.rsrc rd // draining side
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] mcnt, next_mcnt;
    logic out_v, next_out_v;
    logic [WIDTH-1:0] out_d, next_out_d;
    logic push, pop, take, to_mem;

    // occupancy, pointers and output stage
    always_comb
    begin
        wr.level = 5'(mcnt + {{AW{1'b0}}, out_v});
        wr.ready = (mcnt + {{AW{1'b0}}, out_v}) < (AW+1)'(DEPTH);
        rd.valid = out_v;
        rd.data = out_d;
        push = wr.valid & wr.ready;
        pop = out_v & rd.ready;
        take = ~out_v | pop;
        to_mem = push & ~(take & (mcnt == '0));
        next_wp = to_mem ? AW'(wp + 1'b1) : wp;
        next_rp = rp;
        next_mcnt = mcnt;
        next_out_v = out_v & ~pop;
        next_out_d = out_d;
        if (take && mcnt != '0)
        begin
            next_out_d = mem[rp];
            next_out_v = 1'b1;
            next_rp = AW'(rp + 1'b1);
            next_mcnt = mcnt - 1'b1;
        end
        else if (take && push)
        begin
            next_out_d = wr.data;
            next_out_v = 1'b1;
        end
        if (to_mem)
        begin
            next_mcnt = next_mcnt + 1'b1;
        end
    end

    // storage write and state registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wp <= '0;
            rp <= '0;
            mcnt <= '0;
            out_v <= 1'b0;
            out_d <= '0;
        end
        else
        begin
            if (to_mem)
            begin
                mem[wp] <= wr.data;
            end
            wp <= next_wp;
            rp <= next_rp;
            mcnt <= next_mcnt;
            out_v <= next_out_v;
            out_d <= next_out_d;
        end
    end
endmodule : rqh_fifo

/* hdl/rqh_pkg.sv */
// types shared by the receive queue readout modules
// assumes rqh_regs.svh holds the numeric constants
package rqh_pkg;
    typedef logic [15:0] rqh_word_t;
    typedef logic [11:0] rqh_bc_t;
    typedef enum logic [2:0] {
        RQH_DMA_IDLE = 3'b001,
        RQH_DMA_DUMMY = 3'b010,
        RQH_DMA_STREAM = 3'b100
    } rqh_dma_t;
endpackage : rqh_pkg

/* hdl/rqh_receive_queue.sv */
// receive queue host readout: registers, thresholds, data port stream
// assumes host bus strobes and mac words are synchronous to i_clk
// Operation
// R01: setting the dma-start bit opens a data-port access session
// R02: auto-dequeue releases each frame once the host has read it
// R03: frame-count check has an enable bit and a readable status bit
// R04: byte-count check has an enable bit and a readable status bit
// R05: duration timer check has an enable bit and readable status bit
// R06: header-offset bit inserts two bytes ahead of frame data
// R07: auto-increment advances the queue read position per data access
// R08: frame wait time counted in 1 us ticks against its threshold
// R09: queued bytes above the 16-bit threshold raise interrupt and status
// R10: queued frames at or above 8-bit threshold raise interrupt, status
// R11: frame counter upper byte reports frames queued at the interrupt
// R12: interrupt enable bit 13 gates the receive interrupt output
// R13: writing one clears each interrupt status bit, all ones clears all
// R14: read-only register shows the head frame status word
// R15: read-only register shows the head frame 12-bit byte count
// R16: first data unit of each read session is a dummy value
// R17: host reads each frame up to the next double-word boundary
// R18: clearing the receive interrupt refreshes the frame counter value
// R19: reading the frame counter loads head status and byte count
// R20: after both head registers are read, next frame values load
// R21: second receive control holds checksum enables and filter scheme
// R22: frame kept as status, byte count, then data up to 2000 bytes
// R23: first receive control bit 0 enables receive, bit 10 flow control
// R24: interrupt output active while an enabled status bit is set
`timescale 1ns/1ns
`include "rqh_regs.svh"
module rqh_receive_queue (
    input wire logic i_clk, // system clock, 25 MHz
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_cs_n, // chip select, active low
    input wire logic i_cmd, // 1 address phase, 0 data phase
    input wire logic i_rd_n, // read strobe, active low
    input wire logic i_wr_n, // write strobe, active low
    input wire rqh_pkg::rqh_word_t i_sd, // shared bus, input side
    output rqh_pkg::rqh_word_t o_sd, // shared bus, output side
    output logic o_sd_oe_n, // low while driving the bus
    input wire logic i_rx_valid, // receive word valid from mac
    input wire rqh_pkg::rqh_word_t i_rx_data, // receive word
    input wire logic i_rx_last, // last word of the frame
    input wire rqh_pkg::rqh_word_t i_rx_status, // frame status, on last
    input wire rqh_pkg::rqh_bc_t i_rx_bc, // frame byte count, on last
    output logic o_rx_ready, // queue accepts a word
    output logic o_rx_enable, // reception enabled
    output logic o_rx_flow_en, // receive flow control enabled
    output rqh_pkg::rqh_word_t o_rx_ctrl_two, // checksum/filter control
    output logic o_intr_n // interrupt, active low
);
    import rqh_pkg::*;

    localparam logic [4:0] TICK_LAST = 5'(`RQH_TICK_CYC - 1);
    localparam logic [4:0] LVL_MAX = 5'(`RQH_FIFO_D - 2);
    localparam logic [2:0] HDR_MAX = 3'(`RQH_HDR_D - 2);

    rqh_stream_if wq ();
    rqh_stream_if rq ();

    logic rd_q, wr_q, next_rd_q, next_wr_q;
    logic [7:0] addr, next_addr;
    logic [1:0] lanes, next_lanes;
    rqh_word_t rxc1, rxc2, qctl, dur_thr, bc_thr, interrupt_enable;
    rqh_word_t next_rxc1, next_rxc2, next_qctl, next_dur, next_bct, next_ier;
    logic isr_rx, next_isr, ainc, next_ainc;
    logic [7:0] fc_thr, fc_snap, next_fc_thr, next_fc_snap;
    rqh_word_t hfs, next_hfs;
    rqh_bc_t hbc, next_hbc;
    logic hfs_rd, hbc_rd, next_hfs_rd, next_hbc_rd;
    logic fc_st, bc_st, dt_st, next_fc_st, next_bc_st, next_dt_st;
    rqh_word_t hdr_st [`RQH_HDR_D];
    rqh_bc_t hdr_bc [`RQH_HDR_D];
    logic [1:0] wp, rp, pp, next_wp, next_rp, next_pp;
    logic [2:0] hcnt, next_hcnt;
    logic [15:0] btot, age, next_btot, next_age;
    logic [4:0] tick, next_tick;
    logic us_tick;
    logic [10:0] idx, next_idx, beg_w, dat_w, tot_w;
    logic drain, next_drain;
    rqh_dma_t dma, next_dma;
    rqh_word_t next_sd, rv, wv;
    logic next_oe_n, next_ready, next_intr_n;
    logic rd_stb, wr_stb, reg_rd, reg_wr, isr_clr, fin, have_hdr;
    logic in_data, at_end, word_ok, dread, adv, rel;
    logic fc_hit, bc_hit, dt_hit;

    // byte-lane merge of a host write
    function automatic rqh_word_t merge(rqh_word_t o, rqh_word_t n,
        logic [1:0] l);
        merge = {l[1] ? n[15:8] : o[15:8], l[0] ? n[7:0] : o[7:0]};
    endfunction : merge

    rqh_fifo #(
        .WIDTH(`RQH_FIFO_W),
        .DEPTH(`RQH_FIFO_D)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .wr(wq.dst),
        .rd(rq.rsrc)
    );

    assign o_rx_enable = rxc1[`RQH_C1_EN]; // [R23]
    assign o_rx_flow_en = rxc1[`RQH_C1_FC]; // [R23]
    assign o_rx_ctrl_two = rxc2; // [R21]

    // 1 us tick divider, runs while frames wait
    always_comb
    begin
        us_tick = (hcnt != 3'h0) && (tick == TICK_LAST); // [R08]
        next_tick = (hcnt == 3'h0 || us_tick) ? 5'h00 : 5'(tick + 5'h01);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tick <= 5'h00;
        else
            tick <= next_tick;
    end

    // bus decode, registers, queue bookkeeping and data port
    always_comb
    begin
        next_rd_q = i_rd_n | i_cs_n;
        next_wr_q = i_wr_n | i_cs_n;
        rd_stb = ~i_cs_n & ~i_rd_n & rd_q;
        wr_stb = ~i_cs_n & ~i_wr_n & wr_q;
        reg_rd = rd_stb & ~i_cmd;
        reg_wr = wr_stb & ~i_cmd;
        next_addr = addr;
        next_lanes = lanes;
        if (wr_stb && i_cmd)
        begin
            next_addr = {i_sd[7:2], |i_sd[15:14], 1'b0};
            next_lanes = (|i_sd[15:14]) ? i_sd[15:14] : i_sd[13:12];
        end
        // head frame geometry, in 16-bit words
        have_hdr = hcnt != 3'h0;
        beg_w = qctl[`RQH_QC_HOFF] ? 11'h001 : 11'h000; // [R06]
        dat_w = 11'(({1'b0, hdr_bc[rp]} + 13'h0001) >> 1); // [R22]
        tot_w = 11'(((13'(hdr_bc[rp]) + {10'h000, beg_w[0], 1'b0}
                 + 13'h0003) >> 2) << 1); // [R17]
        in_data = (idx >= beg_w) && (!have_hdr || idx < beg_w + dat_w);
        at_end = have_hdr && (11'(idx + 11'h001) >= tot_w);
        word_ok = !in_data || rq.valid;
        dread = reg_rd && addr == `RQH_A_DATA && dma != RQH_DMA_IDLE;
        adv = (dread && dma == RQH_DMA_STREAM && ainc && word_ok) // [R07]
            || (drain && have_hdr && word_ok);
        rq.ready = adv && in_data;
        rel = adv && at_end && (qctl[`RQH_QC_ADQ] || drain); // [R02]
        next_idx = idx;
        if (rel)
            next_idx = 11'h000;
        else if (adv && !at_end)
            next_idx = 11'(idx + 11'h001);
        next_drain = drain && !rel;
        // receive side: words to buffer, header on last word
        wq.valid = i_rx_valid && o_rx_ready;
        wq.data = i_rx_data;
        fin = wq.valid && i_rx_last;
        next_wp = fin ? 2'(wp + 2'h1) : wp;
        next_rp = rel ? 2'(rp + 2'h1) : rp;
        next_hcnt = 3'(hcnt + {2'h0, fin} - {2'h0, rel});
        next_btot = 16'(btot + (fin ? {4'h0, i_rx_bc} : 16'h0000)
                  - (rel ? {4'h0, hdr_bc[rp]} : 16'h0000));
        next_age = age;
        if (rel || !have_hdr)
            next_age = 16'h0000;
        else if (us_tick && age != 16'hFFFF)
            next_age = 16'(age + 16'h0001); // [R08]
        next_ready = rxc1[`RQH_C1_EN] && wq.level <= LVL_MAX
                   && hcnt <= HDR_MAX;
        // threshold checks
        fc_hit = qctl[`RQH_QC_FCEN] && {5'h00, hcnt} >= fc_thr; // [R10]
        bc_hit = qctl[`RQH_QC_BCEN] && btot > bc_thr; // [R09]
        dt_hit = qctl[`RQH_QC_DTEN] && age > dur_thr; // [R08]
        // read mux
        if (addr == `RQH_A_RXC1)
            rv = rxc1;
        else if (addr == `RQH_A_RXC2)
            rv = rxc2;
        else if (addr == `RQH_A_HFS)
            rv = hfs; // [R14]
        else if (addr == `RQH_A_HBC)
            rv = {4'h0, hbc}; // [R15]
        else if (addr == `RQH_A_DATA)
            rv = (dma == RQH_DMA_STREAM && in_data && rq.valid)
               ? rq.data : 16'h0000; // [R16]
        else if (addr == `RQH_A_QCTL)
            rv = qctl | {3'h0, dt_st, bc_st, fc_st, 10'h000}; // [R03] [R04] [R05]
        else if (addr == `RQH_A_RDP)
            rv = {1'b0, ainc, 3'h0, idx[9:0], 1'b0};
        else if (addr == `RQH_A_DUR)
            rv = dur_thr;
        else if (addr == `RQH_A_BCT)
            rv = bc_thr;
        else if (addr == `RQH_A_IEN)
            rv = interrupt_enable;
        else if (addr == `RQH_A_IST)
            rv = {2'h0, isr_rx, 13'h0000};
        else if (addr == `RQH_A_FCT)
            rv = {fc_snap, fc_thr}; // [R11]
        else
            rv = 16'h0000;
        next_sd = reg_rd ? rv : o_sd;
        next_oe_n = ~(~i_cs_n & ~i_rd_n & ~i_cmd);
        // register writes
        wv = i_sd;
        next_rxc1 = rxc1;
        next_rxc2 = rxc2;
        next_qctl = qctl;
        next_ainc = ainc;
        next_dur = dur_thr;
        next_bct = bc_thr;
        next_ier = interrupt_enable;
        next_fc_thr = fc_thr;
        isr_clr = 1'b0;
        if (reg_wr)
        begin
            if (addr == `RQH_A_RXC1)
                next_rxc1 = merge(rxc1, wv, lanes); // [R23]
            else if (addr == `RQH_A_RXC2)
                next_rxc2 = merge(rxc2, wv, lanes); // [R21]
            else if (addr == `RQH_A_QCTL)
            begin
                next_qctl = merge(qctl, wv, lanes) & `RQH_QC_WMASK;
                if (lanes[0] && wv[`RQH_QC_REL] && have_hdr)
                    next_drain = 1'b1;
            end
            else if (addr == `RQH_A_RDP && lanes[1])
                next_ainc = wv[`RQH_RDP_AINC]; // [R07]
            else if (addr == `RQH_A_DUR)
                next_dur = merge(dur_thr, wv, lanes); // [R08]
            else if (addr == `RQH_A_BCT)
                next_bct = merge(bc_thr, wv, lanes); // [R09]
            else if (addr == `RQH_A_IEN)
                next_ier = merge(interrupt_enable, wv, lanes); // [R12]
            else if (addr == `RQH_A_IST)
                isr_clr = lanes[1] && wv[`RQH_IRQ_RX]; // [R13]
            else if (addr == `RQH_A_FCT && lanes[0])
                next_fc_thr = wv[7:0]; // [R10]
        end
        // sticky status, a new hit wins over the clear
        next_isr = (isr_rx && !isr_clr) || fc_hit || bc_hit || dt_hit; // [R13]
        next_fc_st = (fc_st && !isr_clr) || fc_hit; // [R03]
        next_bc_st = (bc_st && !isr_clr) || bc_hit; // [R04]
        next_dt_st = (dt_st && !isr_clr) || dt_hit; // [R05]
        next_fc_snap = isr_clr ? {5'h00, hcnt} : fc_snap; // [R18]
        next_intr_n = ~(next_isr && next_ier[`RQH_IRQ_RX]); // [R12] [R24]
        // head frame registers loaded by reads
        next_hfs = hfs;
        next_hbc = hbc;
        next_pp = pp;
        next_hfs_rd = hfs_rd || (reg_rd && addr == `RQH_A_HFS);
        next_hbc_rd = hbc_rd || (reg_rd && addr == `RQH_A_HBC);
        if (reg_rd && addr == `RQH_A_FCT)
        begin
            next_hfs = hdr_st[rp]; // [R19]
            next_hbc = hdr_bc[rp];
            next_pp = 2'(rp + 2'h1);
            next_hfs_rd = 1'b0;
            next_hbc_rd = 1'b0;
        end
        else if (next_hfs_rd && next_hbc_rd)
        begin
            next_hfs = hdr_st[pp]; // [R20]
            next_hbc = hdr_bc[pp];
            next_pp = 2'(pp + 2'h1);
            next_hfs_rd = 1'b0;
            next_hbc_rd = 1'b0;
        end
        // data port session
        next_dma = dma;
        case (dma)
            RQH_DMA_IDLE:
                if (next_qctl[`RQH_QC_DMA])
                    next_dma = RQH_DMA_DUMMY; // [R01]
            RQH_DMA_DUMMY:
                if (!next_qctl[`RQH_QC_DMA])
                    next_dma = RQH_DMA_IDLE;
                else if (dread)
                    next_dma = RQH_DMA_STREAM; // [R16]
            RQH_DMA_STREAM:
                if (!next_qctl[`RQH_QC_DMA])
                    next_dma = RQH_DMA_IDLE;
            default:
                next_dma = RQH_DMA_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            addr <= 8'h00;
            lanes <= 2'h0;
            rxc1 <= `RQH_RST16;
            rxc2 <= `RQH_RST16;
            qctl <= `RQH_RST16;
            ainc <= 1'b0;
            dur_thr <= `RQH_RST16;
            bc_thr <= `RQH_RST16;
            interrupt_enable <= `RQH_RST16;
            isr_rx <= 1'b0;
            fc_thr <= 8'h00;
            fc_snap <= 8'h00;
            hfs <= `RQH_RST16;
            hbc <= 12'h000;
            hfs_rd <= 1'b0;
            hbc_rd <= 1'b0;
            fc_st <= 1'b0;
            bc_st <= 1'b0;
            dt_st <= 1'b0;
            wp <= 2'h0;
            rp <= 2'h0;
            pp <= 2'h0;
            hcnt <= 3'h0;
            btot <= 16'h0000;
            age <= 16'h0000;
            idx <= 11'h000;
            drain <= 1'b0;
            dma <= RQH_DMA_IDLE;
            o_sd <= `RQH_RST16;
            o_sd_oe_n <= 1'b1;
            o_rx_ready <= 1'b0;
            o_intr_n <= 1'b1;
        end
        else
        begin
            if (fin)
            begin
                hdr_st[wp] <= i_rx_status; // [R22]
                hdr_bc[wp] <= i_rx_bc;
            end
            rd_q <= next_rd_q;
            wr_q <= next_wr_q;
            addr <= next_addr;
            lanes <= next_lanes;
            rxc1 <= next_rxc1;
            rxc2 <= next_rxc2;
            qctl <= next_qctl;
            ainc <= next_ainc;
            dur_thr <= next_dur;
            bc_thr <= next_bct;
            interrupt_enable <= next_ier;
            isr_rx <= next_isr;
            fc_thr <= next_fc_thr;
            fc_snap <= next_fc_snap;
            hfs <= next_hfs;
            hbc <= next_hbc;
            hfs_rd <= next_hfs_rd;
            hbc_rd <= next_hbc_rd;
            fc_st <= next_fc_st;
            bc_st <= next_bc_st;
            dt_st <= next_dt_st;
            wp <= next_wp;
            rp <= next_rp;
            pp <= next_pp;
            hcnt <= next_hcnt;
            btot <= next_btot;
            age <= next_age;
            idx <= next_idx;
            drain <= next_drain;
            dma <= next_dma;
            o_sd <= next_sd;
            o_sd_oe_n <= next_oe_n;
            o_rx_ready <= next_ready;
            o_intr_n <= next_intr_n;
        end
    end
endmodule : rqh_receive_queue

/* hdl/rqh_regs.svh */
// register offsets, bit positions, reset values and timing counts
// assumes a 16-bit host bus and a 25 MHz system clock
`ifndef RQH_REGS_SVH
`define RQH_REGS_SVH
`define RQH_A_RXC1 8'h74
`define RQH_A_RXC2 8'h76
`define RQH_A_HFS 8'h7C
`define RQH_A_HBC 8'h7E
`define RQH_A_DATA 8'h80
`define RQH_A_QCTL 8'h82
`define RQH_A_RDP 8'h86
`define RQH_A_DUR 8'h8C
`define RQH_A_BCT 8'h8E
`define RQH_A_IEN 8'h90
`define RQH_A_IST 8'h92
`define RQH_A_FCT 8'h9C
`define RQH_QC_REL 0
`define RQH_QC_DMA 3
`define RQH_QC_ADQ 4
`define RQH_QC_FCEN 5
`define RQH_QC_BCEN 6
`define RQH_QC_DTEN 7
`define RQH_QC_HOFF 9
`define RQH_QC_FCST 10
`define RQH_QC_BCST 11
`define RQH_QC_DTST 12
`define RQH_QC_WMASK 16'h02F8
`define RQH_RDP_AINC 14
`define RQH_IRQ_RX 13
`define RQH_C1_EN 0
`define RQH_C1_FC 10
`define RQH_RST16 16'h0000
`define RQH_TICK_NS 1000
`define RQH_CLK_NS 40
`define RQH_TICK_CYC (`RQH_TICK_NS / `RQH_CLK_NS)
`define RQH_FIFO_W 16
`define RQH_FIFO_D 8
`define RQH_HDR_D 4
`endif

/* hdl/rqh_stream_if.sv */
// valid/ready word stream between the queue logic and its buffer
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface rqh_stream_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    logic [4:0] level;
    modport src (output valid, output data, input ready, input level);
    modport dst (input valid, input data, output ready, output level);
    modport rsrc (output valid, output data, input ready);
    modport rdst (input valid, input data, output ready);
endinterface : rqh_stream_if

/* test/receive_queue_host_readout_tb.sv */
// self-checking bench for the receive queue readout block
// assumes the host model drives the bus, the bench the mac side
`timescale 1ns/1ns
`include "rqh_regs.svh"
module receive_queue_host_readout_tb;
    import rqh_pkg::*;
    logic clk, rst_n, cs_n, cmd, rd_n, wr_n, oe_n, rx_valid, rx_last;
    logic rx_ready, rx_en, flow_en, intr_n;
    rqh_word_t sd_in, sd_out, rx_data, rx_status, ctl2, q, ctl;
    rqh_bc_t rx_bc;
    int mismatches = 0, samples_checked = 0, cycles = 0, stalls = 0;
    logic [15:0] fw[$], fst[$];
    int fn[$];
    logic [7:0] ra[11] = '{8'h00, 8'h76, 8'h7C, 8'h7E, 8'h82, 8'h86,
        8'h8C, 8'h8E, 8'h90, 8'h92, 8'h9C};
    rqh_receive_queue u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
        .i_cmd(cmd), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_sd(sd_in),
        .o_sd(sd_out), .o_sd_oe_n(oe_n), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_status(rx_status),
        .i_rx_bc(rx_bc), .o_rx_ready(rx_ready), .o_rx_enable(rx_en),
        .o_rx_flow_en(flow_en), .o_rx_ctrl_two(ctl2), .o_intr_n(intr_n));
    rqh_host_model u_host (.i_clk(clk), .i_rdata(sd_out), .o_cs_n(cs_n),
        .o_cmd(cmd), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sd(sd_in));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    // cuts a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [15:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [15:0] d);
        u_host.acc(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(logic [7:0] a);
        u_host.acc(a, 1'b0, 16'h0000, q);
    endtask : rd
    // one frame of n words into the queue, model kept alongside
    task automatic send(int n);
        fn.push_back(n);
        fst.push_back(16'($urandom));
        for (int k = 0; k < n; k++)
        begin
            fw.push_back(16'($urandom));
            rx_data = fw[$];
            rx_last = (k == n - 1);
            rx_status = fst[$];
            rx_bc = 12'(2 * n);
            rx_valid = 1'b1;
            while (!rx_ready)
            begin
                stalls++;
                @(negedge clk);
            end
            @(negedge clk);
        end
        rx_valid = 1'b0;
        @(negedge clk);
    endtask : send
    // one data port session for the head frame, auto dequeue on
    task automatic drain(logic h);
        int n, w;
        n = fn.pop_front();
        w = ((2 * n + 2 * int'(h) + 3) / 4) * 2;
        wr(`RQH_A_QCTL, {6'h00, h, 9'h018});
        rd(`RQH_A_DATA);
        chk("dummy", 16'h0000, q);
        for (int k = 0; k < w; k++)
        begin
            rd(`RQH_A_DATA);
            if (k < int'(h) || k >= n + int'(h))
                chk("pad", 16'h0000, q);
            else
                chk("data", fw.pop_front(), q);
        end
        wr(`RQH_A_QCTL, 16'h0000);
    endtask : drain
    initial
    begin
        {rst_n, rx_valid, rx_last, rx_data, rx_status, rx_bc} = '0;
        void'($urandom(32'h9E8890AD));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        wr(8'h00, 16'hFFFF);
        foreach (ra[i])
        begin
            rd(ra[i]);
            chk("reset", 16'h0000, q);
        end
        wr(`RQH_A_RXC1, 16'h0401);
        repeat (3) @(negedge clk);
        chk("rx_on", 16'h0003, {14'h0, flow_en, rx_en});
        ctl = 16'($urandom);
        wr(`RQH_A_RXC2, ctl);
        rd(`RQH_A_RXC2);
        chk("ctl2", ctl, q);
        chk("ctl2_pin", ctl, ctl2);
        wr(`RQH_A_FCT, 16'h00FF);
        wr(`RQH_A_BCT, 16'hFFFF);
        wr(`RQH_A_DUR, 16'hFFFF);
        wr(`RQH_A_QCTL, 16'h00E0);
        send(3);
        send(2);
        repeat (100) @(negedge clk);
        rd(`RQH_A_QCTL);
        chk("qctl_idle", 16'h00E0, q);
        rd(`RQH_A_IST);
        chk("ist_idle", 16'h0000, q);
        wr(`RQH_A_FCT, 16'h0002);
        wr(`RQH_A_BCT, 16'h0009);
        wr(`RQH_A_DUR, 16'h0002);
        repeat (100) @(negedge clk);
        rd(`RQH_A_QCTL);
        chk("qctl_hit", 16'h1CE0, q);
        rd(`RQH_A_IST);
        chk("ist_hit", 16'h2000, q);
        chk("intr_off", 16'h0001, 16'(intr_n));
        wr(`RQH_A_IEN, 16'h2000);
        repeat (3) @(negedge clk);
        chk("intr_on", 16'h0000, 16'(intr_n));
        wr(`RQH_A_QCTL, 16'h0000);
        wr(`RQH_A_IST, 16'hFFFF);
        rd(`RQH_A_IST);
        chk("ist_clr", 16'h0000, q);
        chk("intr_clr", 16'h0001, 16'(intr_n));
        rd(`RQH_A_FCT);
        chk("fct", 16'h0202, q);
        for (int i = 0; i < 2; i++)
        begin
            rd(`RQH_A_HFS);
            chk("head_st", fst.pop_front(), q);
            rd(`RQH_A_HBC);
            chk("head_bc", 16'(2 * fn[i]), q);
        end
        wr(`RQH_A_RDP, 16'h4000);
        drain(1'b0);
        drain(1'b1);
        stalls = 0;
        fork
            send(10);
            begin
                repeat (12) @(negedge clk);
                drain(1'b0);
            end
        join
        chk("stall", 16'h0001, 16'(stalls > 0));
        final_report();
    end
endmodule : receive_queue_host_readout_tb

/* test/rqh_host_model.sv */
// host model making shared-bus register accesses
// assumes acc is called from a falling clock edge
`timescale 1ns/1ns
module rqh_host_model (
    input wire logic i_clk, // clock
    input wire rqh_pkg::rqh_word_t i_rdata, // device read data
    output logic o_cs_n, // select, active low
    output logic o_cmd, // 1 address phase
    output logic o_rd_n, // read strobe, active low
    output logic o_wr_n, // write strobe, active low
    output rqh_pkg::rqh_word_t o_sd // bus towards device
);
    import rqh_pkg::*;
    // bus idle at time zero
    initial
    begin
        {o_cs_n, o_cmd, o_rd_n, o_wr_n, o_sd} = 20'hB0000;
    end
    // address phase with byte enables, then one data access
    task automatic acc(logic [7:0] a, logic w, rqh_word_t d,
        output rqh_word_t q);
        for (int p = 0; p < 2; p++)
        begin
            @(negedge i_clk);
            o_cs_n = 1'b0;
            o_cmd = (p == 0);
            o_sd = p ? d : {a[1] ? 4'hC : 4'h3, 4'h0, a[7:2], 2'b00};
            o_wr_n = (p == 1) && !w;
            o_rd_n = (p == 0) || w;
            repeat (2) @(negedge i_clk);
            q = i_rdata;
            o_wr_n = 1'b1;
            o_rd_n = 1'b1;
            o_sd = ~o_sd; // released bus shows no stale value
        end
        o_cs_n = 1'b1;
    endtask : acc
endmodule : rqh_host_model

/* test/rqh_rq_props.sv */
// assertions on the bus and control outputs
// assumes binding to rqh_receive_queue, one clock domain
`timescale 1ns/1ns
module rqh_rq_props (
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset, active low
    input wire logic i_cs_n, // select
    input wire logic i_cmd, // bus phase
    input wire logic i_rd_n, // read strobe
    input wire logic i_wr_n, // write strobe
    input wire rqh_pkg::rqh_word_t o_sd, // read data
    input wire logic o_sd_oe_n, // bus enable, active low
    input wire logic o_rx_enable, // reception on
    input wire logic o_rx_flow_en, // flow control on
    input wire rqh_pkg::rqh_word_t o_rx_ctrl_two, // control two
    input wire logic o_intr_n // interrupt, active low
);
    logic prv_rd, prv_wr, rd_acc, rtk, wtk;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // one access is taken where the strobe falls
    assign rd_acc = !i_cs_n && !i_rd_n && !i_cmd;
    assign rtk = rd_acc && prv_rd;
    assign wtk = !i_cs_n && !i_wr_n && !i_cmd && prv_wr;
    // strobes idle a cycle ago
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            {prv_rd, prv_wr} <= 2'b11;
        else
            {prv_rd, prv_wr} <= {i_cs_n || i_rd_n, i_cs_n || i_wr_n};
    end
    sequence s_rd_held;
        rd_acc ##1 rd_acc;
    endsequence
    sequence s_wr_recent;
        $past(wtk, 1) || $past(wtk, 2) || $past(wtk, 3);
    endsequence
    a_oe_drive: assert property (s_rd_held |-> !o_sd_oe_n)
        else $error("bus idle in a read");
    a_oe_release: assert property (!rd_acc |=> o_sd_oe_n)
        else $error("bus driven outside a read");
    a_sd_cause: assert property ($changed(o_sd) |->
        $past(rtk, 1) || $past(rtk, 2))
        else $error("read data moved, no read");
    a_sd_hold: assert property (s_rd_held |=> $stable(o_sd))
        else $error("read data moved in a read");
    a_ctl_two: assert property ($changed(o_rx_ctrl_two) |->
        s_wr_recent)
        else $error("control two moved, no write");
    a_rx_on: assert property ($changed(o_rx_enable) |-> s_wr_recent)
        else $error("rx enable moved, no write");
    a_flow_on: assert property ($changed(o_rx_flow_en) |-> s_wr_recent)
        else $error("flow enable moved, no write");
    a_intr_clear: assert property ($rose(o_intr_n) |-> s_wr_recent)
        else $error("interrupt cleared, no write");
endmodule : rqh_rq_props
bind rqh_receive_queue rqh_rq_props u_props (.i_clk, .i_rst_n, .i_cs_n,
    .i_cmd, .i_rd_n, .i_wr_n, .o_sd, .o_sd_oe_n, .o_rx_enable,
    .o_rx_flow_en, .o_rx_ctrl_two, .o_intr_n);
